// ### dv/mcsl_chk_sva.sv
// Port checker for the control-signal logic
`timescale 1ns/1ps
module mcsl_chk
	import mcsl_pkg::*;
#(
	parameter logic [FSD_CNT_W-1:0] FSD_MIN_CYC = FSD_CNT_W'(FSD_MIN_CYCLES)
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic flash_busy,
	input wire logic [7:0] radio_band,
	input wire logic tx_2g,
	input wire logic tx_3g,
	input wire logic tx_4g,
	input logic general_pin_four_oe,
	input logic general_pin_four_pullup,
	input logic host_wake_line_n,
	input logic band_antenna_select,
	input logic tx_activity,
	input logic dereg_req,
	input logic power_down
);
	// ------
	// Properties
	// ------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// Sampled reset in the band and TX antecedents: the edge that releases reset
	// still sees the outputs cleared, whatever the inputs already hold
	a_band_high: assert property (rst_b && radio_band == BAND_700 |=> band_antenna_select)
		else $error("band select low");
	a_band_low: assert property (rst_b && radio_band != BAND_700 |=> !band_antenna_select)
		else $error("band select high");
	a_band_settle: assert property ((rst_b && $stable(radio_band)) [*2]
		|-> band_antenna_select == (radio_band == BAND_700)) else $error("band select stale");
	a_tx_active: assert property (rst_b && (tx_2g | tx_3g | tx_4g) |=> tx_activity)
		else $error("tx activity low");
	a_tx_idle: assert property (rst_b && !(tx_2g | tx_3g | tx_4g) |=> !tx_activity)
		else $error("tx activity high");
	a_pullup_no_drive: assert property (general_pin_four_pullup |-> !general_pin_four_oe) else $error("pin driven");
	a_flush_wait: assert property (!power_down && flash_busy |=> !power_down) else $error("off during flash work");
	// Only a write to the event register may lift the wake request
	a_wake_hold: assert property (!host_wake_line_n && !(reg_wr && reg_addr == REG_EVENT)
		&& !$past(reg_wr && reg_addr == REG_EVENT) |=> !host_wake_line_n) else $error("wake lost");
	c_off: cover property ($rose(power_down));
	c_dereg: cover property (dereg_req);
	c_wake: cover property ($fell(host_wake_line_n));
	c_band: cover property ($rose(band_antenna_select));
endmodule // mcsl_chk

bind mcsl_top mcsl_chk #(.FSD_MIN_CYC(FSD_MIN_CYC)) mcsl_chk_inst (.core_clk(core_clk), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .flash_busy(flash_busy), .radio_band(radio_band), .tx_2g(tx_2g),
	.tx_3g(tx_3g), .tx_4g(tx_4g), .general_pin_four_oe(general_pin_four_oe),
	.general_pin_four_pullup(general_pin_four_pullup), .host_wake_line_n(host_wake_line_n),
	.band_antenna_select(band_antenna_select), .tx_activity(tx_activity), .dereg_req(dereg_req),
	.power_down(power_down));

// ### dv/mcsl_host_model.sv
// Host side model: drives the shutdown pin and resolves its level
`timescale 1ns/1ps
module mcsl_host_model (
	input wire logic core_clk,
	input wire logic pin_oe,
	input wire logic pin_out,
	input wire logic pin_pullup,
	output logic pin_level
);
	// ------
	// Pin state
	// ------
	logic host_low = 1'b0; // Host pulls the pin low
	logic float_val = 1'b0; // Open pin wanders, so a missing pull-up is seen
	always @(posedge core_clk) begin
		float_val <= ~float_val;
	end
	// Host low wins, then the device driver, then the pull-up
	assign pin_level = host_low ? 1'b0 : pin_oe ? pin_out : pin_pullup ? 1'b1 : float_val;
	// ------
	// Low pulse of n cycles; ignition is taken as high beforehand
	// ------
	task automatic pulse_low(input int n);
		@(posedge core_clk);
		host_low <= 1'b1;
		repeat (n) @(posedge core_clk);
		host_low <= 1'b0;
	endtask
endmodule // mcsl_host_model

// ### dv/tb.sv
// Self-checking testbench for the control-signal logic
`timescale 1ns/1ps
module tb
	import mcsl_pkg::*;
;
	// ------
	// Signals
	// ------
	localparam logic [FSD_CNT_W-1:0] FSD = 20'h00008; // Short count keeps the run brief
	logic core_clk, rst_b, reg_wr, reg_rd, incoming_call, incoming_message, notify_req;
	logic flash_busy, dereg_done, tx_2g, tx_3g, tx_4g, pin_level, pin_out, pin_oe, pin_pu;
	logic host_wake_line_n, band_antenna_select, tx_activity, notify_out, shutdown_notify, dereg_req, power_down;
	logic [7:0] reg_addr, radio_band;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic seen_dereg, seen_snotify, seen_notify; // Sticky monitors, cleared by reset
	logic [7:0] bands [6] = '{8'h11, 8'h05, 8'h11, 8'h12, 8'h10, 8'h11};
	int n_fail, checks, i;
	mcsl_top #(.FSD_MIN_CYC(FSD)) mcsl_top_inst (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.incoming_call(incoming_call), .incoming_message(incoming_message), .notify_req(notify_req),
		.flash_busy(flash_busy), .dereg_done(dereg_done), .radio_band(radio_band), .tx_2g(tx_2g), .tx_3g(tx_3g),
		.tx_4g(tx_4g), .general_pin_four_in(pin_level), .general_pin_four_out(pin_out), .general_pin_four_oe(pin_oe),
		.general_pin_four_pullup(pin_pu), .host_wake_line_n(host_wake_line_n),
		.band_antenna_select(band_antenna_select), .tx_activity(tx_activity), .notify_out(notify_out),
		.shutdown_notify(shutdown_notify), .dereg_req(dereg_req), .power_down(power_down));
	mcsl_host_model mcsl_host_model_inst (.core_clk(core_clk), .pin_oe(pin_oe), .pin_out(pin_out),
		.pin_pullup(pin_pu), .pin_level(pin_level));
	// ------
	// Clock, monitors, watchdog
	// ------
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			{seen_dereg, seen_snotify, seen_notify} <= 3'h0;
		end else begin
			seen_dereg <= seen_dereg | dereg_req;
			seen_snotify <= seen_snotify | shutdown_notify;
			seen_notify <= seen_notify | notify_out;
		end
	end
	initial begin
		repeat (4000) @(posedge core_clk);
		n_fail++;
		give_verdict;
	end
	// ------
	// Tasks
	// ------
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic do_reset;
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic pulse3(input logic [2:0] v);
		@(posedge core_clk);
		{notify_req, incoming_message, incoming_call} <= v;
		@(posedge core_clk);
		{notify_req, incoming_message, incoming_call} <= 3'h0;
	endtask
	task automatic chk(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic give_verdict;
		if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ------
	// Tests
	// ------
	initial begin
		{rst_b, reg_wr, reg_rd, incoming_call, incoming_message, notify_req} = 6'h0;
		{flash_busy, dereg_done, tx_2g, tx_3g, tx_4g} = 5'h0;
		{reg_addr, radio_band, reg_wdata} = 48'h0;
		n_fail = 0;
		checks = 0;
		do_reset;
		cyc(1);
		chk("wake_idle", 1'b1, host_wake_line_n);
		rd(REG_CTRL, d);
		chk("ctrl_reset", 1'b1, d === 32'h0);
		wr(8'h20, 32'hffffffff);
		rd(8'h20, d);
		chk("unmapped", 1'b1, d === 32'h0);
		rd(REG_CTRL, d);
		chk("ctrl_kept", 1'b1, d === 32'h0);
		// Band select follows each band, also a one-cycle blip
		foreach (bands[j]) begin
			@(posedge core_clk) radio_band <= bands[j];
			cyc(2);
			chk("band", bands[j] == BAND_700, band_antenna_select);
		end
		@(posedge core_clk) radio_band <= 8'h05;
		@(posedge core_clk) radio_band <= 8'h11;
		#1 chk("band_blip", 1'b0, band_antenna_select);
		// Every radio combination
		for (i = 0; i < 8; i++) begin
			@(posedge core_clk) {tx_4g, tx_3g, tx_2g} <= i[2:0];
			cyc(2);
			chk("tx", i != 0, tx_activity);
		end
		// Wake events ignored until enabled, then each one raises the request
		pulse3(3'b111);
		cyc(2);
		chk("wake_off", 1'b1, host_wake_line_n);
		wr(REG_CTRL, 32'h1);
		for (i = 0; i < 3; i++) begin
			pulse3(3'b001 << i);
			cyc(1);
			chk("wake_evt", 1'b0, host_wake_line_n);
			rd(REG_STATUS, d);
			chk("st_wake", 1'b0, d[ST_WAKE]);
			wr(REG_EVENT, 32'h2);
			cyc(2);
			chk("wake_rel", 1'b1, host_wake_line_n);
		end
		wr(REG_EVENT, 32'h1);
		cyc(2);
		chk("wake_sw", 1'b0, host_wake_line_n);
		// Pin four as plain output: a long low must not shut down
		wr(REG_CTRL, 32'h1c);
		cyc(2);
		chk("pin_oe", 1'b1, pin_oe);
		chk("pin_out", 1'b1, pin_level);
		mcsl_host_model_inst.pulse_low(3 * FSD);
		cyc(10);
		chk("pd_unconf", 1'b0, power_down);
		// Pin four as shutdown input
		wr(REG_CTRL, 32'h06);
		cyc(3 * FSD);
		chk("pullup", 1'b1, pin_pu);
		chk("pin_idle", 1'b1, pin_level);
		chk("pd_open", 1'b0, power_down);
		mcsl_host_model_inst.pulse_low(FSD);
		cyc(10);
		chk("pd_short", 1'b0, power_down);
		rd(REG_STATUS, d);
		chk("seen_short", 1'b0, d[ST_FSD_SEEN]);
		@(posedge core_clk) flash_busy <= 1'b1;
		mcsl_host_model_inst.pulse_low(FSD + 4);
		cyc(15);
		chk("pd_flash", 1'b0, power_down);
		rd(REG_STATUS, d);
		chk("seen_long", 1'b1, d[ST_FSD_SEEN]);
		chk("st_busy", 1'b1, d[ST_BUSY]);
		@(posedge core_clk) flash_busy <= 1'b0;
		cyc(4);
		chk("pd_fast", 1'b1, power_down);
		chk("no_dereg", 1'b0, seen_dereg);
		// Normal software poweroff
		do_reset;
		pulse3(3'b100);
		wr(REG_CMD, 32'h1);
		cyc(3);
		chk("notify", 1'b1, seen_notify);
		chk("dereg", 1'b1, dereg_req);
		@(posedge core_clk) dereg_done <= 1'b1;
		@(posedge core_clk) dereg_done <= 1'b0;
		cyc(4);
		chk("pd_norm", 1'b1, power_down);
		chk("sd_note", 1'b1, seen_snotify);
		// Fast software poweroff mutes every notification
		do_reset;
		wr(REG_CMD, 32'h3);
		pulse3(3'b100);
		cyc(8);
		chk("pd_sw_fast", 1'b1, power_down);
		chk("muted", 1'b0, seen_notify | seen_snotify);
		chk("skip_dereg", 1'b0, seen_dereg);
		rd(REG_STATUS, d);
		chk("st_mute", 1'b1, d[ST_SUPPRESS]);
		chk("st_off", 1'b1, d[ST_OFF]);
		chk("st_band", 1'b1, d[ST_BAND]);
		chk("st_tx", 1'b1, d[ST_TX]);
		// Read data stand one cycle only, then fall back to zero
		cyc(1);
		chk("rdata_gone", 1'b1, reg_rdata === 32'h0);
		give_verdict;
	end
endmodule // tb

// ### hdl/mcsl_band_select.sv
// Antenna band select output driven from the band in use
`timescale 1ns/1ps
module mcsl_band_select
	import mcsl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [7:0] radio_band,
	output logic band_antenna_select
);

	logic sel_reg, sel_next; // Registered select level

	// Re-evaluated every cycle, so even brief scan hops show up;
	// one cycle of delay sits far inside BAND_MAX_CYCLES
	always_comb begin
		sel_next = (radio_band == BAND_700);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_reg <= 1'b0;
		end else begin
			sel_reg <= sel_next;
		end
	end

	assign band_antenna_select = sel_reg;

endmodule // mcsl_band_select

// ### hdl/mcsl_low_pulse_timer.sv
// Synchroniser and low pulse width timer for the fast shutdown input
`timescale 1ns/1ps
module mcsl_low_pulse_timer
	import mcsl_pkg::*;
#(
	parameter logic [FSD_CNT_W-1:0] MIN_CYCLES = FSD_CNT_W'(FSD_MIN_CYCLES)
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic pin_in,
	input wire logic enable,
	output logic pulse_seen
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic sync1_reg; // First stage, read only by second
	logic sync2_reg; // Stable copy of the pin
	logic [FSD_CNT_W-1:0] cnt_reg, cnt_next; // Cycles low so far
	logic fired_reg, fired_next; // Once per low pulse
	logic seen_reg, seen_next;

	// Two-stage synchroniser
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
		end
	end

	// Count low cycles; fire when the low time passes the minimum
	always_comb begin
		cnt_next = cnt_reg;
		fired_next = fired_reg;
		seen_next = 1'b0;
		if (!enable || sync2_reg) begin
			// Short or aborted pulses are simply forgotten
			cnt_next = '0;
			fired_next = 1'b0;
		end else if (!fired_reg) begin
			if (cnt_reg == MIN_CYCLES) begin
				// Low for MIN_CYCLES+1 samples: strictly longer than minimum
				seen_next = 1'b1;
				fired_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			fired_reg <= 1'b0;
			seen_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			fired_reg <= fired_next;
			seen_reg <= seen_next;
		end
	end

	assign pulse_seen = seen_reg;

endmodule // mcsl_low_pulse_timer

// ### hdl/mcsl_pkg.sv
// Constants, register map and types for the module control-signal logic
package mcsl_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	// Least low time on the shutdown input, in milliseconds
	localparam int FSD_MIN_TIME_MS = 1;
	// Rounded up to whole cycles: 40000 at 40 MHz
	localparam int FSD_MIN_CYCLES = (FSD_MIN_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Longest band select delay, in microseconds
	localparam int BAND_MAX_DELAY_US = 10;
	// Rounded down to whole cycles: 400 at 40 MHz
	localparam int BAND_MAX_CYCLES = (BAND_MAX_DELAY_US * 1000) / CLK_PERIOD_NS;
	// Width of the pulse counter
	localparam int FSD_CNT_W = 20;

	// ------------------------------------------------------------
	// Band coding
	// ------------------------------------------------------------
	localparam logic [7:0] BAND_700 = 8'h11;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_EVENT = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;

	// Control register fields
	localparam int CTRL_WAKE_EN = 0;
	localparam int CTRL_PIN4_FSD = 1;
	localparam int CTRL_FSD_ARM = 2;
	localparam int CTRL_PIN4_OUT = 3;
	localparam int CTRL_PIN4_OE = 4;
	localparam int CTRL_W = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

	// Command register fields (write only, pulses)
	localparam int CMD_POWEROFF = 0;
	localparam int CMD_FAST = 1;

	// Event register fields (write only, pulses)
	localparam int EVT_RAISE = 0;
	localparam int EVT_RELEASE = 1;

	// Status register fields
	localparam int ST_WAKE = 0;
	localparam int ST_FSD_SEEN = 1;
	localparam int ST_BAND = 2;
	localparam int ST_TX = 3;
	localparam int ST_BUSY = 4;
	localparam int ST_OFF = 5;
	localparam int ST_SUPPRESS = 6;

	// ------------------------------------------------------------
	// Shutdown sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SD_IDLE,
		SD_FLUSH,
		SD_DEREG,
		SD_NOTIFY,
		SD_OFF
	} mcsl_state_type;

endpackage

// ### hdl/mcsl_top.sv
// Module control-signal logic: wake line, fast shutdown, band and TX outputs
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module mcsl_top
	import mcsl_pkg::*;
#(
	// Low cycles beyond which a shutdown pulse counts
	parameter logic [FSD_CNT_W-1:0] FSD_MIN_CYC = FSD_CNT_W'(FSD_MIN_CYCLES)
) (
	input wire logic core_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Firmware events
	input wire logic incoming_call,
	input wire logic incoming_message,
	input wire logic notify_req,
	input wire logic flash_busy,
	input wire logic dereg_done,
	// Radio state
	input wire logic [7:0] radio_band,
	input wire logic tx_2g,
	input wire logic tx_3g,
	input wire logic tx_4g,
	// General pin four
	input wire logic general_pin_four_in,
	output logic general_pin_four_out,
	output logic general_pin_four_oe,
	output logic general_pin_four_pullup,
	// Control outputs
	output logic host_wake_line_n,
	output logic band_antenna_select,
	output logic tx_activity,
	output logic notify_out,
	output logic shutdown_notify,
	output logic dereg_req,
	output logic power_down
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_reg, ctrl_next; // Software configuration
	logic [31:0] rdata_reg, rdata_next; // Read data, one cycle late
	logic wake_reg, wake_next; // High while wake is requested
	logic fsd_seen_reg, fsd_seen_next; // Sticky: pulse detected
	mcsl_state_type state_reg, state_next; // Shutdown sequencer
	logic fast_reg, fast_next; // Current shutdown skips deregistration
	logic suppress_reg, suppress_next; // Notifications muted
	logic notify_reg, notify_next; // Forwarded notification pulse
	logic sdn_reg, sdn_next; // Shutdown notification pulse
	logic tx_reg, tx_next; // Transmit activity level
	logic fsd_pulse; // One cycle: qualified shutdown pulse
	logic fsd_pin; // Shutdown input as seen by the timer
	logic pin4_fsd; // Pin four configured for shutdown
	logic wr_ctrl, wr_cmd, wr_evt; // Decoded write strobes
	logic soft_off, soft_fast; // Software poweroff command
	logic wake_cause; // Any event that wants the host awake

	// ------------------------------------------------------------
	// Pin four routing
	// ------------------------------------------------------------
	assign pin4_fsd = ctrl_reg[CTRL_PIN4_FSD];
	// Unconfigured pin reads as idle high, so it never shuts down
	assign fsd_pin = pin4_fsd ? general_pin_four_in : 1'b1;
	// Pull-up keeps an open configured pin at its inactive level
	assign general_pin_four_pullup = pin4_fsd;
	// As a shutdown input the pin is never driven by us
	assign general_pin_four_oe = ctrl_reg[CTRL_PIN4_OE] & ~pin4_fsd;
	assign general_pin_four_out = ctrl_reg[CTRL_PIN4_OUT];

	// ------------------------------------------------------------
	// Sub-blocks
	// ------------------------------------------------------------
	// Ignition ordering before the low pulse is the host's duty;
	// the timer only measures width on the synchronised pin
	mcsl_low_pulse_timer #(
		.MIN_CYCLES(FSD_MIN_CYC)
	) u_timer (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.pin_in(fsd_pin),
		.enable(pin4_fsd & ctrl_reg[CTRL_FSD_ARM]),
		.pulse_seen(fsd_pulse)
	);

	mcsl_band_select u_band (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.radio_band(radio_band),
		.band_antenna_select(band_antenna_select)
	);

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	always_comb begin
		wr_ctrl = 1'b0;
		wr_cmd = 1'b0;
		wr_evt = 1'b0;
		if (reg_wr && reg_addr == REG_CTRL) begin
			wr_ctrl = 1'b1;
		end else if (reg_wr && reg_addr == REG_CMD) begin
			wr_cmd = 1'b1;
		end else if (reg_wr && reg_addr == REG_EVENT) begin
			wr_evt = 1'b1;
		end
	end

	assign soft_off = wr_cmd & reg_wdata[CMD_POWEROFF];
	assign soft_fast = reg_wdata[CMD_FAST];

	// Control register and read data
	always_comb begin
		ctrl_next = ctrl_reg;
		rdata_next = 32'h0000_0000;
		if (wr_ctrl) begin
			ctrl_next = reg_wdata[CTRL_W-1:0];
		end
		if (reg_rd) begin
			if (reg_addr == REG_CTRL) begin
				rdata_next[CTRL_W-1:0] = ctrl_reg;
			end else if (reg_addr == REG_STATUS) begin
				rdata_next[ST_WAKE] = host_wake_line_n;
				rdata_next[ST_FSD_SEEN] = fsd_seen_reg;
				rdata_next[ST_BAND] = band_antenna_select;
				rdata_next[ST_TX] = tx_reg;
				rdata_next[ST_BUSY] = (state_reg != SD_IDLE) && (state_reg != SD_OFF);
				rdata_next[ST_OFF] = (state_reg == SD_OFF);
				rdata_next[ST_SUPPRESS] = suppress_reg;
			end else begin
				// Write-only and unmapped addresses read as zero
				rdata_next = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= CTRL_RESET;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ctrl_reg <= ctrl_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// ------------------------------------------------------------
	// Host wake line
	// ------------------------------------------------------------
	// Muted notifications do not wake the host either
	assign wake_cause = incoming_call | incoming_message | (notify_req & ~suppress_reg);

	always_comb begin
		wake_next = wake_reg;
		if (wr_evt && reg_wdata[EVT_RELEASE]) begin
			wake_next = 1'b0;
		end
		// Raise after release so a same-cycle event is not lost
		if (ctrl_reg[CTRL_WAKE_EN] && wake_cause) begin
			wake_next = 1'b1;
		end
		if (wr_evt && reg_wdata[EVT_RAISE]) begin
			wake_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wake_reg <= 1'b0;
		end else begin
			wake_reg <= wake_next;
		end
	end

	// Idle high, low means wake up
	assign host_wake_line_n = ~wake_reg;

	// ------------------------------------------------------------
	// Notification path
	// ------------------------------------------------------------
	always_comb begin
		notify_next = notify_req & ~suppress_reg;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			notify_reg <= 1'b0;
		end else begin
			notify_reg <= notify_next;
		end
	end

	assign notify_out = notify_reg;

	// ------------------------------------------------------------
	// Shutdown sequencer
	// ------------------------------------------------------------
	// Flash work always completes first; a fast shutdown then goes
	// straight to power down and never asks for deregistration
	always_comb begin
		state_next = state_reg;
		fast_next = fast_reg;
		suppress_next = suppress_reg;
		fsd_seen_next = fsd_seen_reg | fsd_pulse;
		sdn_next = 1'b0;
		case (state_reg)
			SD_IDLE: begin
				if (fsd_pulse) begin
					// Pin pulse wins over a software command in the same cycle
					state_next = SD_FLUSH;
					fast_next = 1'b1;
				end else if (soft_off) begin
					state_next = SD_FLUSH;
					fast_next = soft_fast;
					suppress_next = soft_fast;
				end
			end
			SD_FLUSH: begin
				if (!flash_busy) begin
					if (fast_reg) begin
						state_next = SD_OFF;
					end else begin
						state_next = SD_DEREG;
					end
				end
			end
			SD_DEREG: begin
				if (dereg_done) begin
					state_next = SD_NOTIFY;
				end
			end
			SD_NOTIFY: begin
				// Announce only when not muted
				sdn_next = ~suppress_reg;
				state_next = SD_OFF;
			end
			SD_OFF: begin
				// Held until reset
				state_next = SD_OFF;
			end
			default: begin
				state_next = SD_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= SD_IDLE;
			fast_reg <= 1'b0;
			suppress_reg <= 1'b0;
			fsd_seen_reg <= 1'b0;
			sdn_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			fast_reg <= fast_next;
			suppress_reg <= suppress_next;
			fsd_seen_reg <= fsd_seen_next;
			sdn_reg <= sdn_next;
		end
	end

	assign shutdown_notify = sdn_reg;
	// Never raised on the fast path
	assign dereg_req = (state_reg == SD_DEREG);
	assign power_down = (state_reg == SD_OFF);

	// ------------------------------------------------------------
	// Transmit activity
	// ------------------------------------------------------------
	always_comb begin
		tx_next = tx_2g | tx_3g | tx_4g;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_reg <= 1'b0;
		end else begin
			tx_reg <= tx_next;
		end
	end

	assign tx_activity = tx_reg;

endmodule // mcsl_top
